// ---- bench/dsss_ppdu_framer_interleaver_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsss_ppdu_framer_interleaver_tb;
  import ppdu_pkg::*;
  localparam logic [7:0] SFD_V = 8'hb4; // Arbitrary value
  localparam logic [31:0] PRE32_V = 32'h5a3c_96e1; // Arbitrary value
  logic mclk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, busy_o, frame_done_o;
  logic [7:0] pay_data_i;
  logic pay_valid_i, pay_ready_o, obit_valid_o, obit_ready_i, far_slow = 1'b0;
  frame_cfg_t cfg_i = '0;
  bit_beat_t obit_o;
  logic [1:0] frag_size_i = 2'h0;
  logic [9:0] enc_sym_i = 10'h000, il_sym_o;
  logic enc_valid_i = 1'b0, enc_ready_o, il_valid_o, il_last_o, il_ready_i = 1'b0, il_slow = 1'b0;
  logic [2:0] exp_q[$];
  int bad_count = 0, checks_done = 0, pay_base = 0;

  dsss_ppdu_framer #(.SFD_VALUE(SFD_V), .PRE32_VALUE(PRE32_V), .SYM_W(10)) u_dut (
    .mclk_i, .rst_i, .start_i, .cfg_i, .busy_o, .frame_done_o, .pay_data_i, .pay_valid_i,
    .pay_ready_o, .obit_o, .obit_valid_o, .obit_ready_i, .frag_size_i, .enc_sym_i,
    .enc_valid_i, .enc_ready_o, .il_sym_o, .il_valid_o, .il_last_o, .il_ready_i);

  far_end_model u_far (.mclk_i(mclk_i), .rst_i(rst_i), .slow_i(far_slow),
    .pay_ready_i(pay_ready_o), .pay_data_o(pay_data_i), .pay_valid_o(pay_valid_i),
    .obit_i(obit_o), .obit_valid_i(obit_valid_o), .obit_ready_o(obit_ready_i));

  // Clock and spreader-side stall pattern
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) il_ready_i <= il_slow ? ~il_ready_i : 1'b1;

  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // Queue n expected bits, leftmost written bit first or LSB first
  task automatic push(input logic [31:0] v, input int n, input bit msb);
    for (int i = 0; i < n; i++) exp_q.push_back({2'b00, msb ? v[n - 1 - i] : v[i]});
  endtask : push

  task automatic push_pay(input int l);
    for (int k = 0; k <= l; k++) push(8'h35 + 8'(pay_base + k) * 8'h1d, 8, 0);
    pay_base += l + 1;
  endtask : push_pay

  // Start a frame, try a second start while busy, then compare the whole bit stream
  task automatic send_frame(input frame_cfg_t c);
    int n;
    n = 0;
    exp_q[0][2] = 1'b1;
    exp_q[exp_q.size() - 1][1] = 1'b1;
    u_far.seen.delete();
    @(posedge mclk_i);
    start_i <= 1'b1;
    cfg_i <= c;
    @(posedge mclk_i);
    start_i <= 1'b0;
    #1 check(32'(busy_o), 32'h1);
    @(posedge mclk_i);
    start_i <= 1'b1;
    cfg_i <= '{1'b1, 1'b0, 3'h0, 11'h000};
    @(posedge mclk_i);
    start_i <= 1'b0;
    do begin
      @(posedge mclk_i);
      #1 n++;
    end while (frame_done_o !== 1'b1 && n < 30000);
    check(32'(frame_done_o), 32'h1);
    check(32'(busy_o), 32'h0);
    repeat (4) @(posedge mclk_i);
    check(u_far.seen.size(), exp_q.size());
    foreach (exp_q[i]) check(32'(u_far.seen[i]), 32'(exp_q[i]));
  endtask : send_frame

  // Feed one fragment of symbols numbered by index and check the reordered output
  task automatic il_run(input logic [1:0] code, input int n);
    logic [10:0] got[$];
    int k, nn, bits;
    bits = (n == 256) ? 8 : 9;
    k = 0;
    @(posedge mclk_i);
    frag_size_i <= code;
    fork
      begin
        for (int i = 0; i < n; i++) begin
          enc_sym_i <= 10'(i);
          enc_valid_i <= 1'b1;
          do @(posedge mclk_i); while (enc_ready_o !== 1'b1);
        end
        enc_valid_i <= 1'b0;
        #1 check(32'(enc_ready_o), 32'h0);
      end
      while (got.size() < n) begin
        @(posedge mclk_i);
        if (il_valid_o === 1'b1 && il_ready_i === 1'b1) got.push_back({il_last_o, il_sym_o});
      end
    join
    check(32'(enc_ready_o), 32'h1);
    check(got.size(), n);
    for (int m = 0; m < (1 << bits); m++) begin
      nn = 0;
      for (int b = 0; b < bits; b++) if ((m >> b) & 1) nn |= 1 << (bits - 1 - b);
      if (nn < n) begin
        check(32'(got[k]), {21'h0, k == n - 1, 10'(nn)});
        k++;
      end
    end
  endtask : il_run

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  // Fixed size, no sync header: two payload octets alone
  task automatic sc_fixed();
    exp_q.delete();
    push_pay(1);
    send_frame('{1'b1, 1'b0, 3'h0, 11'h001});
  endtask : sc_fixed

  // Fixed size with the sync header kept: no length header after the delimiter
  task automatic sc_fixed_shr();
    exp_q.delete();
    push(16'b0011_1111_0101_1001, 16, 1);
    push(SFD_V, 8, 0);
    push_pay(2);
    send_frame('{1'b1, 1'b1, 3'h2, 11'h002});
  endtask : sc_fixed_shr

  // Two-octet preamble, delimiter, short header, with both sides stalling
  task automatic sc_short();
    far_slow <= 1'b1;
    exp_q.delete();
    push(16'b0011_1111_0101_1001, 16, 1);
    push(SFD_V, 8, 0);
    push({7'h03, 1'b0}, 8, 0);
    push_pay(3);
    send_frame('{1'b0, 1'b0, 3'h2, 11'h003});
    far_slow <= 1'b0;
  endtask : sc_short

  // No preamble and the largest short header value
  task automatic sc_max_short();
    exp_q.delete();
    push(SFD_V, 8, 0);
    push({7'h7f, 1'b0}, 8, 0);
    push_pay(127);
    send_frame('{1'b0, 1'b0, 3'h0, 11'h07f});
  endtask : sc_max_short

  // Four-octet preamble and the smallest long header value
  task automatic sc_long();
    exp_q.delete();
    push(PRE32_V, 32, 1);
    push(SFD_V, 8, 0);
    push({11'h080, 4'h0, 1'b1}, 16, 0);
    push_pay(128);
    send_frame('{1'b0, 1'b0, 3'h4, 11'h080});
  endtask : sc_long

  task automatic sc_il256();
    il_slow <= 1'b0;
    il_run(FRAG_256, 256);
  endtask : sc_il256

  task automatic sc_il384();
    il_slow <= 1'b1;
    il_run(FRAG_384, 384);
  endtask : sc_il384

  task automatic sc_il512();
    il_slow <= 1'b1;
    il_run(FRAG_512, 512);
  endtask : sc_il512

  // Main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    sc_fixed();
    sc_fixed_shr();
    sc_short();
    sc_max_short();
    sc_long();
    sc_il256();
    sc_il384();
    sc_il512();
    end_of_test();
  end

  // Watchdog, about five times the expected run
  initial begin
    #300000;
    bad_count++;
    end_of_test();
  end
endmodule : dsss_ppdu_framer_interleaver_tb
`default_nettype wire

// ---- bench/far_end_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module far_end_model
  import ppdu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic pay_ready_i,
  output logic [7:0] pay_data_o,
  output logic pay_valid_o,
  input wire bit_beat_t obit_i,
  input wire logic obit_valid_i,
  output logic obit_ready_o
);
  logic [7:0] idx_r;
  logic [1:0] gap_r;
  logic [2:0] seen[$];

  // ***********************************************************
  // Octet source
  // ***********************************************************
  // Idle data is the inverse of the last octet, so a late sample is caught
  assign pay_data_o = pay_valid_o ? 8'h35 + idx_r * 8'h1d : ~(8'h35 + (idx_r - 8'h01) * 8'h1d);

  // Each octet is held until taken; slow mode leaves a gap after each one
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      idx_r <= 8'h00;
      gap_r <= 2'h0;
      pay_valid_o <= 1'b0;
    end else if (pay_valid_o && pay_ready_i) begin
      pay_valid_o <= 1'b0;
      idx_r <= idx_r + 8'h01;
      gap_r <= slow_i ? 2'h3 : 2'h0;
    end else if (!pay_valid_o) begin
      if (gap_r == 2'h0) begin
        pay_valid_o <= 1'b1;
      end else begin
        gap_r <= gap_r - 2'h1;
      end
    end
  end

  // ***********************************************************
  // Bit sink
  // ***********************************************************
  // Bits are kept in arrival order with their flags, LSB first as sent
  always @(posedge mclk_i) begin
    obit_ready_o <= rst_i ? 1'b0 : (slow_i ? ~obit_ready_o : 1'b1);
    if (!rst_i && obit_valid_i && obit_ready_o) begin
      seen.push_back({obit_i.first, obit_i.last, obit_i.data});
    end
  end
endmodule : far_end_model
`default_nettype wire

// ---- core/dsss_ppdu_framer.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsss_ppdu_framer
  import ppdu_pkg::*;
#(
  parameter logic [7:0] SFD_VALUE = SFD_DEFAULT,
  parameter logic [31:0] PRE32_VALUE = PRE32_DEFAULT,
  parameter int SYM_W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  // Frame request
  input wire logic start_i,
  input wire frame_cfg_t cfg_i,
  output logic busy_o,
  output logic frame_done_o,
  // Payload octets from the MAC side
  input wire logic [7:0] pay_data_i,
  input wire logic pay_valid_i,
  output logic pay_ready_o,
  // Serial bits towards the encoder
  output bit_beat_t obit_o,
  output logic obit_valid_o,
  input wire logic obit_ready_i,
  // Encoded symbols into the interleaver
  input wire logic [1:0] frag_size_i,
  input wire logic [SYM_W-1:0] enc_sym_i,
  input wire logic enc_valid_i,
  output logic enc_ready_o,
  // Reordered symbols towards the spreader
  output logic [SYM_W-1:0] il_sym_o,
  output logic il_valid_o,
  output logic il_last_o,
  input wire logic il_ready_i
);

  // ***********************************************************
  // Framer state
  // ***********************************************************
  framer_st_t r;
  framer_st_t n;
  logic emit;
  logic accept;
  logic shr_on;
  logic [31:0] pre_load;
  logic [5:0] pre_bits;

  generate
    if (SYM_W < 1) begin : g_bad_sym
      $error("dsss_ppdu_framer: SYM_W must be at least 1");
    end
  endgenerate

  // A bit leaves the shifter only when the output slot is free
  assign emit = (r.cnt != 6'h00) && (!r.ovalid || obit_ready_i);
  assign accept = r.pay_rdy && pay_valid_i;

  // Sync header always precedes a variable frame; optional when fixed
  assign shr_on = !cfg_i.fixed || cfg_i.shr_en;

  // Preamble image chosen at start; written patterns go leftmost first
  always_comb begin
    pre_load = 32'h0000_0000;
    pre_bits = 6'h00;
    if (cfg_i.pre_octets[2]) begin
      pre_load = rev32(PRE32_VALUE);
      pre_bits = PRE32_BITS;
    end else if (cfg_i.pre_octets[1]) begin
      pre_load = rev32({PRE16_PATTERN, 16'h0000});
      pre_bits = PRE16_BITS;
    end
  end

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    n = r;
    n.done = 1'b0;
    if (r.ovalid && obit_ready_i) begin
      n.ovalid = 1'b0;
    end

    // Shift one bit out, LSB first, for every field alike
    if (emit) begin
      n.ob.data = r.sh[0];
      n.ob.first = r.first_pend;
      n.ob.last = (r.st == FR_PAY) && (r.cnt == 6'h01) && (r.left == 12'h000);
      n.ovalid = 1'b1;
      n.first_pend = 1'b0;
      n.sh = {1'b0, r.sh[31:1]};
      n.cnt = r.cnt - 6'h01;
    end

    unique case (r.st)
      FR_IDLE: begin
        n.busy = 1'b0;
        if (start_i) begin
          n.cfg = cfg_i;
          n.left = {1'b0, cfg_i.len_m1} + 12'h001;
          n.busy = 1'b1;
          n.first_pend = 1'b1;
          if (shr_on && pre_bits != 6'h00) begin
            n.st = FR_PRE;
            n.sh = pre_load;
            n.cnt = pre_bits;
          end else if (shr_on) begin
            n.st = FR_SFD;
            n.sh = {24'h000000, SFD_VALUE};
            n.cnt = OCTET_BITS;
          end else begin
            // Fixed frame with no sync header: payload alone
            n.st = FR_PAY;
            n.cnt = 6'h00;
          end
        end
      end

      FR_PRE: begin
        // Delimiter follows the last preamble bit with one idle slot
        if (r.cnt == 6'h00) begin
          n.st = FR_SFD;
          n.sh = {24'h000000, SFD_VALUE};
          n.cnt = OCTET_BITS;
        end
      end

      FR_SFD: begin
        if (r.cnt == 6'h00) begin
          if (r.cfg.fixed) begin
            n.st = FR_PAY;
          end else begin
            n.st = FR_PHR;
            if (r.cfg.len_m1 < SHORT_HDR_LIMIT) begin
              // Flag 0 goes first, then the 7-bit count
              n.sh = {24'h000000, r.cfg.len_m1[6:0], 1'b0};
              n.cnt = OCTET_BITS;
            end else begin
              // Flag 1, four reserved, 11-bit count; low octet first
              n.sh = {16'h0000, r.cfg.len_m1, HDR_RESERVED, 1'b1};
              n.cnt = LONG_HDR_BITS;
            end
          end
        end
      end

      FR_PHR: begin
        if (r.cnt == 6'h00) begin
          n.st = FR_PAY;
        end
      end

      FR_PAY: begin
        if (accept) begin
          n.sh = {24'h000000, pay_data_i};
          n.cnt = OCTET_BITS;
          n.left = r.left - 12'h001;
        end else if (r.cnt == 6'h00 && r.left == 12'h000) begin
          // Final bit sits in the output slot; the frame is complete
          n.st = FR_IDLE;
          n.done = 1'b1;
          n.busy = 1'b0;
        end
      end
    endcase

    // Registered ready: only ask for an octet once the shifter is empty
    n.pay_rdy = (n.st == FR_PAY) && (n.cnt == 6'h00) && (n.left != 12'h000) && !accept;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= FR_IDLE;
    end else begin
      r <= n;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign busy_o = r.busy;
  assign frame_done_o = r.done;
  assign pay_ready_o = r.pay_rdy;
  assign obit_o = r.ob;
  assign obit_valid_o = r.ovalid;

  // The encoder lies outside, so its symbols re-enter here
  pbri_interleaver #(
    .SYM_W(SYM_W)
  ) u_interleaver (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .frag_size_i(frag_size_i),
    .sym_i(enc_sym_i),
    .sym_valid_i(enc_valid_i),
    .sym_ready_o(enc_ready_o),
    .out_sym_o(il_sym_o),
    .out_valid_o(il_valid_o),
    .out_last_o(il_last_o),
    .out_ready_i(il_ready_i)
  );

  // ***********************************************************
  // Checks
  // ***********************************************************
  property p_hold_bit;
    @(posedge mclk_i) disable iff (rst_i)
    (obit_valid_o && !obit_ready_i) |=> (obit_valid_o && $stable(obit_o));
  endproperty
  a_hold_bit: assert property (p_hold_bit)
    else $error("output bit changed while stalled");

  property p_short_header;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == FR_SFD && n.st == FR_PHR && r.cfg.len_m1 < SHORT_HDR_LIMIT)
      |=> (r.cnt == OCTET_BITS && r.sh[0] == 1'b0 && r.sh[7:1] == r.cfg.len_m1[6:0]);
  endproperty
  a_short_header: assert property (p_short_header)
    else $error("short header malformed");

  property p_long_header;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == FR_SFD && n.st == FR_PHR && r.cfg.len_m1 >= SHORT_HDR_LIMIT)
      |=> (r.cnt == LONG_HDR_BITS && r.sh[0] == 1'b1 && r.sh[4:1] == HDR_RESERVED
           && r.sh[15:5] == r.cfg.len_m1);
  endproperty
  a_long_header: assert property (p_long_header)
    else $error("long header malformed");

  property p_fixed_no_header;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st != FR_IDLE && r.cfg.fixed) |-> (r.st != FR_PHR);
  endproperty
  a_fixed_no_header: assert property (p_fixed_no_header)
    else $error("length header sent for a fixed frame");

  property p_pre_length;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == FR_IDLE && n.st == FR_PRE)
      |=> (r.cnt == (r.cfg.pre_octets[2] ? PRE32_BITS : PRE16_BITS));
  endproperty
  a_pre_length: assert property (p_pre_length)
    else $error("preamble length wrong");

  property p_pre16_image;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == FR_IDLE && n.st == FR_PRE && !cfg_i.pre_octets[2])
      |=> (r.sh[15:0] == 16'h9afc);
  endproperty
  a_pre16_image: assert property (p_pre16_image)
    else $error("16-bit preamble pattern wrong");

  property p_sfd_follows;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == FR_PRE && r.cnt == 6'h00)
      |=> (r.st == FR_SFD && r.cnt == OCTET_BITS && r.sh[7:0] == SFD_VALUE);
  endproperty
  a_sfd_follows: assert property (p_sfd_follows)
    else $error("delimiter does not follow preamble");

  property p_header_then_payload;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == FR_PHR && r.cnt == 6'h00) |=> (r.st == FR_PAY);
  endproperty
  a_header_then_payload: assert property (p_header_then_payload)
    else $error("payload does not follow header");

  property p_done_after_last;
    @(posedge mclk_i) disable iff (rst_i)
    (emit && r.st == FR_PAY && r.cnt == 6'h01 && r.left == 12'h000)
      |=> obit_o.last ##1 frame_done_o;
  endproperty
  a_done_after_last: assert property (p_done_after_last)
    else $error("frame end not flagged after final payload bit");

  // A second start may follow at once, so only the pulse width is held here
  property p_done_pulse;
    @(posedge mclk_i) disable iff (rst_i)
    frame_done_o |=> !frame_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("frame done held longer than one cycle");

  property p_pay_ready_empty;
    @(posedge mclk_i) disable iff (rst_i)
    pay_ready_o |-> (r.st == FR_PAY && r.cnt == 6'h00 && r.left != 12'h000);
  endproperty
  a_pay_ready_empty: assert property (p_pay_ready_empty)
    else $error("payload octet requested while shifter busy");

  property p_fixed_bare;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == FR_IDLE && start_i && cfg_i.fixed && !cfg_i.shr_en)
      |=> (r.st == FR_PAY && busy_o);
  endproperty
  a_fixed_bare: assert property (p_fixed_bare)
    else $error("bare fixed frame did not go straight to payload");

  property p_variable_sync;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == FR_IDLE && start_i && !cfg_i.fixed) |=> (r.st == FR_PRE || r.st == FR_SFD);
  endproperty
  a_variable_sync: assert property (p_variable_sync)
    else $error("variable frame started without a sync header");

  property p_no_preamble;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == FR_IDLE && start_i && !cfg_i.fixed && cfg_i.pre_octets[2:1] == 2'b00)
      |=> (r.st == FR_SFD && r.sh[7:0] == SFD_VALUE);
  endproperty
  a_no_preamble: assert property (p_no_preamble)
    else $error("zero preamble did not start at the delimiter");

endmodule : dsss_ppdu_framer
`default_nettype wire

// ---- core/pbri_interleaver.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbri_interleaver
  import ppdu_pkg::*;
#(
  parameter int SYM_W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [1:0] frag_size_i,
  input wire logic [SYM_W-1:0] sym_i,
  input wire logic sym_valid_i,
  output logic sym_ready_o,
  output logic [SYM_W-1:0] out_sym_o,
  output logic out_valid_o,
  output logic out_last_o,
  input wire logic out_ready_i
);

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    il_state_t st;
    logic [1:0] size;
    logic [8:0] wr;
    logic [8:0] m;
    logic [8:0] ecnt;
    logic [SYM_W-1:0] osym;
    logic ovalid;
    logic olast;
  } il_st_t;

  il_st_t r;
  il_st_t n;
  logic [SYM_W-1:0] mem [0:511];
  logic [SYM_W-1:0] rd_sym;
  logic [8:0] idx;
  logic [9:0] flen;
  logic slot;
  logic wr_en;

  generate
    if (SYM_W < 1) begin : g_bad_width
      $error("pbri_interleaver: SYM_W must be at least 1");
    end
  endgenerate

  function automatic logic [9:0] frag_len(input logic [1:0] code);
    unique case (code)
      FRAG_384: return LEN_384;
      FRAG_512: return LEN_512;
      default: return LEN_256;
    endcase
  endfunction : frag_len

  // Size is taken from the input at the first symbol and held thereafter
  assign flen = frag_len(r.size);
  assign idx = rev_index(r.m, r.size != FRAG_256);
  assign rd_sym = mem[idx];
  assign slot = !r.ovalid || out_ready_i;
  assign wr_en = (r.st == IL_FILL) && sym_valid_i;

  // Fill the whole fragment, then walk M and send the surviving indices
  always_comb begin
    n = r;
    if (r.ovalid && out_ready_i) begin
      n.ovalid = 1'b0;
    end
    unique case (r.st)
      IL_FILL: begin
        if (sym_valid_i) begin
          if (r.wr == 9'h000) begin
            n.size = frag_size_i;
          end
          if ({1'b0, r.wr} == frag_len(r.wr == 9'h000 ? frag_size_i : r.size) - 10'h001) begin
            n.st = IL_DRAIN;
            n.m = 9'h000;
            n.ecnt = 9'h000;
          end else begin
            n.wr = r.wr + 9'h001;
          end
        end
      end
      IL_DRAIN: begin
        if (slot) begin
          n.m = r.m + 9'h001;
          if ({1'b0, idx} < flen) begin
            n.osym = rd_sym;
            n.ovalid = 1'b1;
            n.olast = ({1'b0, r.ecnt} == flen - 10'h001);
            n.ecnt = r.ecnt + 9'h001;
            if (n.olast) begin
              n.st = IL_FILL;
              n.wr = 9'h000;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= IL_FILL;
    end else begin
      r <= n;
    end
  end

  // The array has no reset; only filled entries are ever read
  always_ff @(posedge mclk_i) begin
    if (wr_en) begin
      mem[r.wr] <= sym_i;
    end
  end

  assign sym_ready_o = r.st[0];
  assign out_sym_o = r.osym;
  assign out_valid_o = r.ovalid;
  assign out_last_o = r.olast;

  // ***********************************************************
  // Checks
  // ***********************************************************
  property p_ready_after_last;
    @(posedge mclk_i) disable iff (rst_i)
    (out_valid_o && out_last_o) |-> sym_ready_o;
  endproperty
  a_ready_after_last: assert property (p_ready_after_last)
    else $error("interleaver not ready after final symbol");

  property p_pruned_skip;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == IL_DRAIN && slot && {1'b0, idx} >= flen) |=> !out_valid_o;
  endproperty
  a_pruned_skip: assert property (p_pruned_skip)
    else $error("pruned index was emitted");

  property p_reversed_pick;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == IL_DRAIN && slot && {1'b0, idx} < flen) |=> (out_valid_o && out_sym_o == $past(rd_sym));
  endproperty
  a_reversed_pick: assert property (p_reversed_pick)
    else $error("output symbol is not the bit-reversed input");

  property p_last_position;
    @(posedge mclk_i) disable iff (rst_i)
    (r.st == IL_DRAIN && slot && {1'b0, idx} < flen && {1'b0, r.ecnt} == flen - 10'h001)
      |-> (r.m == ((r.size == FRAG_384) ? 9'h1fe : (r.size == FRAG_512) ? 9'h1ff : 9'h0ff));
  endproperty
  a_last_position: assert property (p_last_position)
    else $error("fragment ended at the wrong M");

endmodule : pbri_interleaver
`default_nettype wire

// ---- core/ppdu_pkg.sv ----
package ppdu_pkg;

  // ***********************************************************
  // Field sizes and patterns
  // ***********************************************************
  localparam logic [15:0] PRE16_PATTERN = 16'h3f59;
  localparam logic [7:0] SFD_DEFAULT = 8'h00;
  localparam logic [31:0] PRE32_DEFAULT = 32'h0000_0000;
  localparam logic [5:0] PRE16_BITS = 6'h10;
  localparam logic [5:0] PRE32_BITS = 6'h20;
  localparam logic [5:0] OCTET_BITS = 6'h08;
  localparam logic [5:0] LONG_HDR_BITS = 6'h10;
  localparam logic [10:0] SHORT_HDR_LIMIT = 11'h080;
  localparam logic [3:0] HDR_RESERVED = 4'h0;

  // ***********************************************************
  // Interleaver fragment sizes
  // ***********************************************************
  localparam logic [1:0] FRAG_256 = 2'h0;
  localparam logic [1:0] FRAG_384 = 2'h1;
  localparam logic [1:0] FRAG_512 = 2'h2;
  localparam logic [9:0] LEN_256 = 10'h100;
  localparam logic [9:0] LEN_384 = 10'h180;
  localparam logic [9:0] LEN_512 = 10'h200;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef struct packed {
    logic fixed;
    logic shr_en;
    logic [2:0] pre_octets;
    logic [10:0] len_m1;
  } frame_cfg_t;

  typedef struct packed {
    logic data;
    logic first;
    logic last;
  } bit_beat_t;

  typedef enum logic [4:0] {
    FR_IDLE = 5'h01,
    FR_PRE = 5'h02,
    FR_SFD = 5'h04,
    FR_PHR = 5'h08,
    FR_PAY = 5'h10
  } fr_state_t;

  typedef enum logic [1:0] {
    IL_FILL = 2'h1,
    IL_DRAIN = 2'h2
  } il_state_t;

  typedef struct packed {
    fr_state_t st;
    frame_cfg_t cfg;
    logic [31:0] sh;
    logic [5:0] cnt;
    logic [11:0] left;
    logic first_pend;
    logic pay_rdy;
    bit_beat_t ob;
    logic ovalid;
    logic busy;
    logic done;
  } framer_st_t;

  // Bit reversal over 9 bits, or over the low 8 when nine is clear
  function automatic logic [8:0] rev_index(input logic [8:0] v, input logic nine);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 0; i < 9; i++) begin
      r[i] = v[8 - i];
    end
    if (!nine) begin
      r = {1'b0, r[8:1]};
    end
    return r;
  endfunction : rev_index

  // Mirror of a 32-bit word, so a written pattern shifts out leftmost first
  function automatic logic [31:0] rev32(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31 - i];
    end
    return r;
  endfunction : rev32

endpackage : ppdu_pkg
